// ### hw/cpx_pkg.sv
/*
 * cpx_pkg: constants shared by the crossbar port pin logic.
 * Assumes an 8-bit special-function-register bus with byte and bit strobes.
 */
package cpx_pkg;
    // widths and counts
    localparam int DATA_W = 8;      // register width
    localparam int NUM_PORTS = 4;   // crossbar ports 0..3
    localparam int NUM_PINS = 32;   // pins on ports 0..3
    localparam int NUM_SIG = 10;    // peripheral signals the crossbar routes
    localparam int PIN_IDX_W = 6;   // room for pin index plus an overflow bit

    // register offsets on the sfr bus
    localparam logic [7:0] ADDR_P0_DATA = 8'h80;
    localparam logic [7:0] ADDR_P1_DATA = 8'h90;
    localparam logic [7:0] ADDR_P2_DATA = 8'ha0;
    localparam logic [7:0] ADDR_P3_DATA = 8'hb0;
    localparam logic [7:0] ADDR_P0_MODE = 8'ha4;
    localparam logic [7:0] ADDR_P1_MODE = 8'ha5;
    localparam logic [7:0] ADDR_P2_MODE = 8'ha6;
    localparam logic [7:0] ADDR_P3_MODE = 8'ha7;
    localparam logic [7:0] ADDR_XBR0 = 8'he1;
    localparam logic [7:0] ADDR_CROSSBAR_CONFIG_REG_TWO = 8'he3;
    localparam logic [7:0] ADDR_P7_DATA = 8'hf8;
    localparam logic [7:0] ADDR_P7_MODE = 8'hf9;

    // crossbar_config_reg_zero fields: peripheral enables
    localparam int XBR0_SMB_BIT = 0;
    localparam int XBR0_SPI_BIT = 1;
    localparam int XBR0_UART0_BIT = 2;
    localparam int XBR0_UART1_BIT = 3;
    localparam int XBR0_SPI4_BIT = 4;  // spi uses spi_select_line
    // crossbar_config_reg_two fields
    localparam int CROSSBAR_CONFIG_REG_TWO_CROSSBAR_ENABLE_BIT_BIT = 4; // crossbar_enable_bit

    // reset values
    localparam logic [7:0] PORT_DATA_RST = 8'hff;
    localparam logic [7:0] PORT_MODE_RST = 8'h00;  // all open-drain
    localparam logic [7:0] XBR_RST = 8'h00;
    localparam logic [7:0] P7_DATA_RST = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // peripheral signal indices, in crossbar priority order
    localparam int SIG_SDA = 0;
    localparam int SIG_SCL = 1;
    localparam int SIG_SCK = 2;
    localparam int SIG_MISO = 3;
    localparam int SIG_MOSI = 4;
    localparam int SIG_NSS = 5;   // spi_select_line
    localparam int SIG_TX0 = 6;   // uart0_transmit_line
    localparam int SIG_RX0 = 7;   // uart0_receive_line
    localparam int SIG_TX1 = 8;
    localparam int SIG_RX1 = 9;
    // signals that are inputs only: their pins are never driven
    localparam logic [NUM_SIG-1:0] SIG_INPUT_ONLY = 10'h280;
endpackage : cpx_pkg

// ### hw/cpx_xbar_decode.sv
/*
 * cpx_xbar_decode: priority crossbar, maps enabled peripheral signals to pins.
 * Assumes synchronised pin levels and peripheral drive requests on CLK_IN's domain.
 */
`timescale 1ns/1ps
module cpx_xbar_decode import cpx_pkg::*; (
    // configuration
    input wire logic [7:0] xbr0_in,
    // peripheral side
    input wire logic [NUM_SIG-1:0] periph_val_in,
    input wire logic [NUM_SIG-1:0] periph_drv_in,
    output logic [NUM_SIG-1:0] periph_in_out,
    // pin side
    input wire logic [NUM_PINS-1:0] pin_level_in,
    output logic [NUM_PINS-1:0] pin_alloc_out,
    output logic [NUM_PINS-1:0] pin_val_out,
    output logic [NUM_PINS-1:0] pin_drv_out
);
    logic [NUM_SIG-1:0] sig_en;                // signal routed to a pin
    logic [PIN_IDX_W-1:0] sig_pin [NUM_SIG];   // pin taken by each signal

    // whole peripherals only: each signal follows its peripheral's enable; spi_select_line also needs XBR0_SPI4_BIT
    function automatic logic sig_enabled(input int s, input logic [7:0] x);
        unique case (s)
            SIG_SDA, SIG_SCL: return x[XBR0_SMB_BIT];
            SIG_SCK, SIG_MISO, SIG_MOSI: return x[XBR0_SPI_BIT];
            SIG_NSS: return x[XBR0_SPI_BIT] & x[XBR0_SPI4_BIT];
            SIG_TX0, SIG_RX0: return x[XBR0_UART0_BIT];
            SIG_TX1, SIG_RX1: return x[XBR0_UART1_BIT];
            default: return 1'b0;
        endcase
    endfunction : sig_enabled

    // hand out pins in priority order; disabled peripherals take none
    always_comb begin
        logic [PIN_IDX_W-1:0] nxt;
        nxt = '0;
        for (int s = 0; s < NUM_SIG; s++) begin
            sig_en[s] = sig_enabled(s, xbr0_in);
            sig_pin[s] = nxt;
            if (sig_en[s]) begin
                nxt = nxt + PIN_IDX_W'(1);  // each enabled set gives its own pinout
            end
        end
    end

    // per-pin view of the allocation
    always_comb begin
        pin_alloc_out = '0;
        pin_val_out = '0;
        pin_drv_out = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            for (int s = 0; s < NUM_SIG; s++) begin
                if (sig_en[s] && sig_pin[s] == PIN_IDX_W'(p)) begin
                    pin_alloc_out[p] = 1'b1;
                    pin_val_out[p] = periph_val_in[s];
                    // input-only signals never drive their pin
                    pin_drv_out[p] = periph_drv_in[s] & ~SIG_INPUT_ONLY[s];
                end
            end
        end
    end

    // pin levels back to peripherals; unrouted inputs idle high
    always_comb begin
        for (int s = 0; s < NUM_SIG; s++) begin
            periph_in_out[s] = sig_en[s] ? pin_level_in[sig_pin[s][4:0]] : 1'b1;
        end
    end
endmodule : cpx_xbar_decode

// ### hw/cpx_port_ctrl.sv
/*
 * cpx_port_ctrl: port data latches, output modes, crossbar gating and port 7.
 * Assumes the cpu's sfr bus on CLK_IN, pins as in/out/enable triples,
 * and the memory interface on the same clock.
 */
`timescale 1ns/1ps
module cpx_port_ctrl import cpx_pkg::*; (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // sfr bus
    input wire logic [7:0] SFR_ADDR_IN,
    input wire logic [7:0] SFR_WDATA_IN,
    input wire logic SFR_WR_IN,
    input wire logic SFR_BIT_WR_IN,
    input wire logic [2:0] SFR_BIT_IDX_IN,
    input wire logic SFR_RD_IN,
    input wire logic SFR_RMW_IN,
    output logic [7:0] SFR_RDATA_OUT,
    // ports 0-3 pins
    input wire logic [NUM_PINS-1:0] PIN_IN,
    output logic [NUM_PINS-1:0] PIN_OUT,
    output logic [NUM_PINS-1:0] PIN_OE_N_OUT,
    // peripherals
    input wire logic [NUM_SIG-1:0] PERIPH_VAL_IN,
    input wire logic [NUM_SIG-1:0] PERIPH_DRV_IN,
    output logic [NUM_SIG-1:0] PERIPH_IN_OUT,
    // port 7 pins
    input wire logic [7:0] P7_PIN_IN,
    output logic [7:0] P7_PIN_OUT,
    output logic [7:0] P7_OE_N_OUT,
    // external memory interface on port 7
    input wire logic EMIF_EN_IN,
    input wire logic EMIF_DRV_IN,
    input wire logic [7:0] EMIF_DATA_IN,
    output logic [7:0] EMIF_DATA_OUT
);
    logic [NUM_PINS-1:0] port_latch_q;  // port data latches 0..3
    logic [NUM_PINS-1:0] port_mode_q;   // port_output_mode_reg bits
    logic [7:0] xbr0_q;                 // peripheral enables
    logic [7:0] crossbar_config_reg_two_q;                 // crossbar_config_reg_two
    logic [7:0] p7_latch_q;             // port7_pin_latch
    logic [7:0] p7_mode_q;              // port7_output_mode_reg
    logic [NUM_PINS-1:0] pin_meta_q;    // first synchroniser stage
    logic [NUM_PINS-1:0] pin_sync_q;    // pin levels, safe to use
    logic [7:0] p7_meta_q;
    logic [7:0] p7_sync_q;
    logic [7:0] rdata_q;
    logic [NUM_PINS-1:0] pin_out_q;
    logic [NUM_PINS-1:0] pin_oe_n_q;
    logic [7:0] p7_out_q;
    logic [7:0] p7_oe_n_q;
    logic [NUM_PINS-1:0] xb_alloc;      // pin owned by a peripheral
    logic [NUM_PINS-1:0] xb_val;
    logic [NUM_PINS-1:0] xb_drv;
    logic [NUM_PINS-1:0] pin_out_d;
    logic [NUM_PINS-1:0] pin_oe_n_d;
    logic [7:0] p7_out_d;
    logic [7:0] p7_oe_n_d;
    logic crossbar_enable_bit;                        // crossbar_enable_bit

    // data register address of port k
    function automatic logic [7:0] data_addr(input int k);
        unique case (k)
            0: return ADDR_P0_DATA;
            1: return ADDR_P1_DATA;
            2: return ADDR_P2_DATA;
            default: return ADDR_P3_DATA;
        endcase
    endfunction : data_addr

    // mode register address of port k
    function automatic logic [7:0] mode_addr(input int k);
        unique case (k)
            0: return ADDR_P0_MODE;
            1: return ADDR_P1_MODE;
            2: return ADDR_P2_MODE;
            default: return ADDR_P3_MODE;
        endcase
    endfunction : mode_addr

    // byte write, or single-bit write, applied to an old value
    function automatic logic [7:0] apply_wr(input logic [7:0] old, input logic byte_wr,
                                            input logic bit_wr, input logic [2:0] idx,
                                            input logic [7:0] wd);
        logic [7:0] v;
        v = old;
        if (byte_wr) begin
            v = wd;
        end else if (bit_wr) begin
            v[idx] = wd[0];  // bit value on data bit 0
        end
        return v;
    endfunction : apply_wr

    assign crossbar_enable_bit = crossbar_config_reg_two_q[CROSSBAR_CONFIG_REG_TWO_CROSSBAR_ENABLE_BIT_BIT];

    // two-flop synchronisers on every pin input; only stage two is read
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
            p7_meta_q <= 8'hff;
            p7_sync_q <= 8'hff;
        end else begin
            pin_meta_q <= PIN_IN;
            pin_sync_q <= pin_meta_q;
            p7_meta_q <= P7_PIN_IN;
            p7_sync_q <= p7_meta_q;
        end
    end

    // port data latches and mode bits, ports 0..3
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            port_latch_q <= {NUM_PORTS{PORT_DATA_RST}};
            port_mode_q <= {NUM_PORTS{PORT_MODE_RST}};  // open-drain
        end else begin
            for (int k = 0; k < NUM_PORTS; k++) begin
                // latch always takes the write; an allocated pin just ignores it
                if (SFR_ADDR_IN == data_addr(k)) begin
                    port_latch_q[k*8 +: 8] <= apply_wr(port_latch_q[k*8 +: 8], SFR_WR_IN,
                                                       SFR_BIT_WR_IN, SFR_BIT_IDX_IN, SFR_WDATA_IN);
                end
                // mode registers are byte-only
                if (SFR_WR_IN && SFR_ADDR_IN == mode_addr(k)) begin
                    port_mode_q[k*8 +: 8] <= SFR_WDATA_IN;
                end
            end
        end
    end

    // crossbar configuration; meant to be set once at start-up
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            xbr0_q <= XBR_RST;
            crossbar_config_reg_two_q <= XBR_RST;
        end else if (SFR_WR_IN) begin
            if (SFR_ADDR_IN == ADDR_XBR0) begin
                xbr0_q <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == ADDR_CROSSBAR_CONFIG_REG_TWO) begin
                crossbar_config_reg_two_q <= SFR_WDATA_IN;
            end
        end
    end

    // port 7 latch (bit-addressable) and mode
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            p7_latch_q <= P7_DATA_RST;
            p7_mode_q <= PORT_MODE_RST;
        end else begin
            if (SFR_ADDR_IN == ADDR_P7_DATA) begin
                p7_latch_q <= apply_wr(p7_latch_q, SFR_WR_IN, SFR_BIT_WR_IN,
                                       SFR_BIT_IDX_IN, SFR_WDATA_IN);
            end
            if (SFR_WR_IN && SFR_ADDR_IN == ADDR_P7_MODE) begin
                p7_mode_q <= SFR_WDATA_IN;
            end
        end
    end

    // read data, registered; one cycle after the strobe
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            rdata_q <= UNMAPPED_READ;
        end else if (SFR_RD_IN) begin
            rdata_q <= UNMAPPED_READ;  // unmapped reads give zero
            for (int k = 0; k < NUM_PORTS; k++) begin
                if (SFR_ADDR_IN == data_addr(k)) begin
                    // rmw read phase sees the latch, otherwise the pin
                    rdata_q <= SFR_RMW_IN ? port_latch_q[k*8 +: 8] : pin_sync_q[k*8 +: 8];
                end
                if (SFR_ADDR_IN == mode_addr(k)) begin
                    rdata_q <= port_mode_q[k*8 +: 8];
                end
            end
            if (SFR_ADDR_IN == ADDR_P7_DATA) begin
                rdata_q <= SFR_RMW_IN ? p7_latch_q : p7_sync_q;
            end
            if (SFR_ADDR_IN == ADDR_P7_MODE) begin
                rdata_q <= p7_mode_q;
            end
            if (SFR_ADDR_IN == ADDR_XBR0) begin
                rdata_q <= xbr0_q;
            end
            if (SFR_ADDR_IN == ADDR_CROSSBAR_CONFIG_REG_TWO) begin
                rdata_q <= crossbar_config_reg_two_q;
            end
        end
    end

    // crossbar allocation
    cpx_xbar_decode u_xbar (
        .xbr0_in(xbr0_q),
        .periph_val_in(PERIPH_VAL_IN),
        .periph_drv_in(PERIPH_DRV_IN),
        .periph_in_out(PERIPH_IN_OUT),
        .pin_level_in(pin_sync_q),
        .pin_alloc_out(xb_alloc),
        .pin_val_out(xb_val),
        .pin_drv_out(xb_drv)
    );

    // driver decision for ports 0..3
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            if (xb_alloc[p]) begin
                // peripheral owns value and drive; input signals never drive
                pin_out_d[p] = xb_val[p];
                // mode bit still picks push-pull or open-drain for peripheral outputs
                pin_oe_n_d[p] = ~(crossbar_enable_bit & xb_drv[p] & (port_mode_q[p] | ~xb_val[p]));
            end else begin
                pin_out_d[p] = port_latch_q[p];
                // push-pull drives both levels, open-drain only low
                pin_oe_n_d[p] = ~(crossbar_enable_bit & (port_mode_q[p] | ~port_latch_q[p]));
            end
        end
    end

    // port 7: memory interface overrides the latch while it is enabled
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (EMIF_EN_IN) begin
                // bus drives both levels while its write phase lasts
                p7_out_d[b] = EMIF_DATA_IN[b];
                p7_oe_n_d[b] = ~EMIF_DRV_IN;
            end else begin
                p7_out_d[b] = p7_latch_q[b];
                // high floats when mode bit is zero
                p7_oe_n_d[b] = ~(p7_mode_q[b] | ~p7_latch_q[b]);
            end
        end
    end

    // registered pin drivers; released during reset
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            pin_out_q <= '1;
            pin_oe_n_q <= '1;
            p7_out_q <= 8'hff;
            p7_oe_n_q <= 8'hff;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
            p7_out_q <= p7_out_d;
            p7_oe_n_q <= p7_oe_n_d;
        end
    end

    assign SFR_RDATA_OUT = rdata_q;
    assign PIN_OUT = pin_out_q;
    assign PIN_OE_N_OUT = pin_oe_n_q;
    assign P7_PIN_OUT = p7_out_q;
    assign P7_OE_N_OUT = p7_oe_n_q;
    assign EMIF_DATA_OUT = p7_sync_q;  // read data for the memory interface
endmodule : cpx_port_ctrl

// ### verif/cpx_port_checker.sv
/*
 * cpx_port_checker: concurrent checks on the port pin block's top ports.
 * Assumes binding into cpx_port_ctrl and no read in the same cycle as a write.
 */
`timescale 1ns/1ps
module cpx_port_checker import cpx_pkg::*; (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // sfr bus
    input wire logic [7:0] SFR_ADDR_IN,
    input wire logic [7:0] SFR_WDATA_IN,
    input wire logic SFR_WR_IN,
    input wire logic SFR_BIT_WR_IN,
    input wire logic [2:0] SFR_BIT_IDX_IN,
    input wire logic SFR_RD_IN,
    input wire logic SFR_RMW_IN,
    input wire logic [7:0] SFR_RDATA_OUT,
    // pins and peripherals
    input wire logic [NUM_PINS-1:0] PIN_OE_N_OUT,
    input wire logic [NUM_SIG-1:0] PERIPH_IN_OUT,
    input wire logic [7:0] P7_PIN_IN,
    input wire logic [7:0] P7_PIN_OUT,
    input wire logic [7:0] P7_OE_N_OUT,
    // memory interface
    input wire logic EMIF_EN_IN,
    input wire logic EMIF_DRV_IN,
    input wire logic [7:0] EMIF_DATA_IN,
    input wire logic [7:0] EMIF_DATA_OUT
);
    logic crossbar_enable_bit_q; // mirrored crossbar enable
    logic [7:0] xbr0_q; // mirrored peripheral enables
    logic [7:0] p7_mode_q; // mirrored port 7 modes
    logic [7:0] p7_latch_q; // mirrored port 7 latch
    logic [1:0] live_q; // edges since reset, saturating

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    // register mirrors; a byte write wins over a bit write
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            crossbar_enable_bit_q <= 1'b0;
            xbr0_q <= XBR_RST;
            p7_mode_q <= PORT_MODE_RST;
            p7_latch_q <= P7_DATA_RST;
        end else if (SFR_WR_IN) begin
            case (SFR_ADDR_IN)
                ADDR_CROSSBAR_CONFIG_REG_TWO: crossbar_enable_bit_q <= SFR_WDATA_IN[CROSSBAR_CONFIG_REG_TWO_CROSSBAR_ENABLE_BIT_BIT];
                ADDR_XBR0: xbr0_q <= SFR_WDATA_IN;
                ADDR_P7_MODE: p7_mode_q <= SFR_WDATA_IN;
                ADDR_P7_DATA: p7_latch_q <= SFR_WDATA_IN;
                default: ;
            endcase
        end else if (SFR_BIT_WR_IN && SFR_ADDR_IN == ADDR_P7_DATA) begin
            p7_latch_q[SFR_BIT_IDX_IN] <= SFR_WDATA_IN[0];
        end
    end

    // $past still sees reset-time outputs for a few edges after release
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            live_q <= 2'h0;
        end else if (live_q != 2'h3) begin
            live_q <= live_q + 2'h1;
        end
    end

    AST_XBAR_GATE: assert property (!$past(crossbar_enable_bit_q) |-> &PIN_OE_N_OUT)
        else $error("port driver enabled while crossbar is off");
    AST_P7_OPEN_DRAIN: assert property (
        live_q != 2'h0 && !$past(EMIF_EN_IN) |-> (((P7_OE_N_OUT ^ $past(p7_latch_q))
        | (~P7_OE_N_OUT & P7_PIN_OUT)) & ~$past(p7_mode_q)) == 8'h00)
        else $error("port 7 open-drain pin not following latch");
    AST_P7_PUSH_PULL: assert property (
        live_q != 2'h0 && !$past(EMIF_EN_IN) |-> (((P7_PIN_OUT ^ $past(p7_latch_q))
        | P7_OE_N_OUT) & $past(p7_mode_q)) == 8'h00)
        else $error("port 7 push-pull pin not driving latch");
    AST_EMIF_DRIVE: assert property (
        live_q != 2'h0 && $past(EMIF_EN_IN)
        |-> P7_PIN_OUT == $past(EMIF_DATA_IN) && P7_OE_N_OUT == {8{!$past(EMIF_DRV_IN)}})
        else $error("port 7 not following memory interface");
    AST_EMIF_SYNC: assert property (live_q[1] |-> EMIF_DATA_OUT == $past(P7_PIN_IN, 2))
        else $error("memory interface data not two edges behind pins");
    AST_RD_PIN: assert property (
        SFR_RD_IN && !SFR_RMW_IN && SFR_ADDR_IN == ADDR_P7_DATA && live_q == 2'h3
        |=> SFR_RDATA_OUT == $past(P7_PIN_IN, 3))
        else $error("port 7 read not returning pin levels");
    AST_RD_LATCH: assert property (
        SFR_RD_IN && SFR_RMW_IN && SFR_ADDR_IN == ADDR_P7_DATA |=> SFR_RDATA_OUT == $past(p7_latch_q))
        else $error("modify read not returning latch");
    AST_PERIPH_IDLE: assert property (xbr0_q == XBR_RST |-> &PERIPH_IN_OUT)
        else $error("signal routed with all peripherals off");
endmodule : cpx_port_checker

bind cpx_port_ctrl cpx_port_checker u_cpx_port_checker (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WDATA_IN(SFR_WDATA_IN),
    .SFR_WR_IN(SFR_WR_IN), .SFR_BIT_WR_IN(SFR_BIT_WR_IN), .SFR_BIT_IDX_IN(SFR_BIT_IDX_IN),
    .SFR_RD_IN(SFR_RD_IN), .SFR_RMW_IN(SFR_RMW_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT),
    .PIN_OE_N_OUT(PIN_OE_N_OUT), .PERIPH_IN_OUT(PERIPH_IN_OUT), .P7_PIN_IN(P7_PIN_IN),
    .P7_PIN_OUT(P7_PIN_OUT), .P7_OE_N_OUT(P7_OE_N_OUT), .EMIF_EN_IN(EMIF_EN_IN),
    .EMIF_DRV_IN(EMIF_DRV_IN), .EMIF_DATA_IN(EMIF_DATA_IN), .EMIF_DATA_OUT(EMIF_DATA_OUT)
);

// ### verif/cpx_pin_model.sv
/*
 * cpx_pin_model: board wires on a group of port pins, with pull-ups.
 * Assumes active-low output enables and an outside driver that may override.
 */
`timescale 1ns/1ps
module cpx_pin_model #(
    parameter int WIDTH = 8
) (
    // device side
    input wire logic [WIDTH-1:0] pin_out_in,
    input wire logic [WIDTH-1:0] pin_oe_n_in,
    // outside drivers
    input wire logic [WIDTH-1:0] ext_en_in,
    input wire logic [WIDTH-1:0] ext_val_in,
    // resolved wire level
    output logic [WIDTH-1:0] level_out
);
    // contention is not modelled: the outside driver simply wins
    always_comb begin
        for (int n = 0; n < WIDTH; n++) begin
            if (ext_en_in[n]) begin
                level_out[n] = ext_val_in[n]; // outside pulls the wire
            end else if (!pin_oe_n_in[n]) begin
                level_out[n] = pin_out_in[n];
            end else begin
                level_out[n] = 1'b1; // released wire: pull-up
            end
        end
    end
endmodule : cpx_pin_model

// ### verif/cpx_testbench.sv
/*
 * testbench: self-checking bench for the crossbar port pin block.
 * Assumes pull-ups on every pin and nothing else driving the block.
 */
`timescale 1ns/1ps
module testbench import cpx_pkg::*; ;
    typedef struct packed {logic [7:0] mode; logic [7:0] data; logic [7:0] oe_n;} cpx_row_t;
    typedef struct packed {logic [7:0] xbr0; logic [3:0] oe_n;} cpx_xrow_t;
    logic clk = 1'b0, rst = 1'b1; // clock, reset
    logic wr = 1'b0, bwr = 1'b0, rd = 1'b0, rmw = 1'b0; // sfr strobes
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata; // sfr data
    logic [2:0] bidx = 3'h0; // bit number
    logic [31:0] pin_out, pin_oe_n, pin_lvl, ext_en = 32'h0, ext_val = 32'h0; // ports 0..3
    logic [9:0] pval = 10'h000, pdrv = 10'h000, psig; // peripherals
    logic [7:0] p7_out, p7_oe_n, p7_lvl, p7_ext = 8'h00, emif_data = 8'h00, emif_q; // port 7
    logic emif_en = 1'b0, emif_drv = 1'b0; // memory interface
    int num_errors = 0, checks = 0;
    // gpio rows: enable expected from mode and latch
    cpx_row_t rows [4] = '{'{8'h00, 8'h55, 8'h55}, '{8'hff, 8'h55, 8'h00},
        '{8'h0f, 8'hf0, 8'hf0}, '{8'ha5, 8'hff, 8'h5a}};
    // pinout rows: low nibble enables per peripheral set, all drives requested
    cpx_xrow_t xrows [7] = '{'{8'h00, 4'hf}, '{8'h01, 4'hc}, '{8'h02, 4'h8}, '{8'h12, 4'h0},
        '{8'h04, 4'he}, '{8'h08, 4'he}, '{8'h0c, 4'ha}};

    cpx_port_ctrl u_cpx_port_ctrl (.CLK_IN(clk), .RESET_IN(rst), .SFR_ADDR_IN(addr),
        .SFR_WDATA_IN(wdata), .SFR_WR_IN(wr), .SFR_BIT_WR_IN(bwr), .SFR_BIT_IDX_IN(bidx),
        .SFR_RD_IN(rd), .SFR_RMW_IN(rmw), .SFR_RDATA_OUT(rdata), .PIN_IN(pin_lvl),
        .PIN_OUT(pin_out), .PIN_OE_N_OUT(pin_oe_n), .PERIPH_VAL_IN(pval), .PERIPH_DRV_IN(pdrv),
        .PERIPH_IN_OUT(psig), .P7_PIN_IN(p7_lvl), .P7_PIN_OUT(p7_out), .P7_OE_N_OUT(p7_oe_n),
        .EMIF_EN_IN(emif_en), .EMIF_DRV_IN(emif_drv), .EMIF_DATA_IN(emif_data), .EMIF_DATA_OUT(emif_q));
    cpx_pin_model #(.WIDTH(NUM_PINS)) u_cpx_pin_model (.pin_out_in(pin_out), .pin_oe_n_in(pin_oe_n),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_lvl));
    cpx_pin_model #(.WIDTH(8)) u_cpx_pin_model_p7 (.pin_out_in(p7_out), .pin_oe_n_in(p7_oe_n),
        .ext_en_in(p7_ext), .ext_val_in(8'h00), .level_out(p7_lvl));

    // 250 MHz system clock
    always #2 clk = ~clk;

    // one sfr cycle: strobe set after an edge, taken at the next
    task automatic sfr(input logic w, b, r, m, input logic [7:0] a, d, input logic [2:0] i);
        @(posedge clk);
        {wr, bwr, rd, rmw} <= {w, b, r, m};
        addr <= a;
        wdata <= d;
        bidx <= i;
        @(posedge clk);
        {wr, bwr, rd, rmw} <= 4'h0;
        #1;
    endtask : sfr
    task automatic wr8(input logic [7:0] a, d);
        sfr(1'b1, 1'b0, 1'b0, 1'b0, a, d, 3'h0);
    endtask : wr8
    task automatic rd8(input logic [7:0] a, input logic m);
        sfr(1'b0, 1'b0, 1'b1, m, a, 8'h00, 3'h0);
    endtask : rd8
    // pins settle, then two sync edges
    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask : settle
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // watchdog, far beyond the couple of hundred cycles of the run
    initial begin
        #40000;
        num_errors++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(pin_oe_n, 32'hffffffff);
        rd8(ADDR_P7_DATA, 1'b1);
        chk(rdata, P7_DATA_RST);
        rd8(ADDR_P0_MODE, 1'b0);
        chk(rdata, PORT_MODE_RST);
        wr8(ADDR_P0_MODE, 8'hff); // push-pull low, crossbar still off
        wr8(ADDR_P0_DATA, 8'h00);
        settle();
        chk(pin_oe_n[7:0], 8'hff);
        wr8(ADDR_CROSSBAR_CONFIG_REG_TWO, 8'h10); // enable first, pinout later
        foreach (rows[k]) begin
            wr8(ADDR_P0_MODE, rows[k].mode);
            wr8(ADDR_P0_DATA, rows[k].data);
            settle();
            chk(pin_oe_n[7:0], rows[k].oe_n);
            chk(pin_out[7:0], rows[k].data);
        end
        // bit write, outside low on pin 2: pins versus latch
        wr8(ADDR_P0_MODE, 8'h00);
        wr8(ADDR_P0_DATA, 8'hff);
        sfr(1'b0, 1'b1, 1'b0, 1'b0, ADDR_P0_DATA, 8'h00, 3'h5);
        @(posedge clk);
        ext_en <= 32'h4;
        settle();
        rd8(ADDR_P0_DATA, 1'b0);
        chk(rdata, 8'hdb);
        rd8(ADDR_P0_DATA, 1'b1);
        chk(rdata, 8'hdf);
        sfr(1'b0, 1'b1, 1'b0, 1'b0, ADDR_P0_MODE, 8'h01, 3'h0); // mode bit write is ignored
        rd8(ADDR_P0_MODE, 1'b0);
        chk(rdata, 8'h00);
        wr8(ADDR_P0_DATA, 8'hff);
        pdrv <= 10'h3ff; // receive lines ask too, must stay released
        foreach (xrows[k]) begin
            wr8(ADDR_XBR0, xrows[k].xbr0);
            settle();
            chk(pin_oe_n[3:0], xrows[k].oe_n);
        end
        // uart0 alone: transmit on pin 0, receive on pin 1 held low outside
        wr8(ADDR_P0_DATA, 8'h00);
        wr8(ADDR_XBR0, 8'h04);
        pval <= 10'h040;
        ext_en <= 32'h2;
        settle();
        chk(pin_oe_n[0], 1'b1); // open-drain transmit high floats
        wr8(ADDR_P0_MODE, 8'hff);
        settle();
        chk(pin_out[0], 1'b1);
        chk(pin_oe_n[0], 1'b0); // push-pull transmit drives high
        chk(psig[SIG_RX0], 1'b0);
        wr8(ADDR_P0_DATA, 8'hff);
        pval <= 10'h000;
        settle();
        chk({pin_out[0], pin_oe_n[1:0]}, 3'h2);
        rd8(ADDR_P0_DATA, 1'b0);
        chk(rdata, 8'hfc);
        wr8(ADDR_XBR0, 8'h00);
        settle();
        chk(psig[SIG_RX0], 1'b1);
        // port 7: mixed modes, outside low on pin 4
        wr8(ADDR_P7_MODE, 8'h0f);
        sfr(1'b0, 1'b1, 1'b0, 1'b0, ADDR_P7_DATA, 8'h00, 3'h7);
        p7_ext <= 8'h10;
        settle();
        chk({p7_out, p7_oe_n}, 16'h7f70);
        rd8(ADDR_P7_DATA, 1'b0);
        chk(rdata, 8'h6f);
        rd8(ADDR_P7_DATA, 1'b1);
        chk(rdata, 8'h7f);
        @(posedge clk);
        {emif_en, emif_drv} <= 2'h3;
        emif_data <= 8'h3c;
        settle();
        chk({p7_out, p7_oe_n, emif_q}, 24'h3c002c);
        emif_drv <= 1'b0;
        settle();
        chk({p7_oe_n, emif_q}, 16'hffef);
        emif_en <= 1'b0;
        // reset in mid-run clears the crossbar enable
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(pin_oe_n, 32'hffffffff);
        complete_run();
    end
endmodule : testbench
